// [hw/apdu_idle_counter.sv]
// saturating inactivity counter advanced by logic clock ticks
`timescale 1ns/1ps
module apdu_idle_counter #(
  parameter int               CNT_W = apdu_pkg::CNT_W,
  parameter logic [CNT_W-1:0] LIMIT = apdu_pkg::IDLE_LIMIT
) (
  input  wire logic             core_clk,  // core clock
  input  wire logic             rst,       // async reset, active high
  input  wire logic             clear,     // restart from zero, wins over tick
  input  wire logic             count_en,  // counting allowed
  input  wire logic             tick,      // one-cycle logic clock edge
  output logic      [CNT_W-1:0] count,     // current count
  output logic                  expired    // count has reached the limit
);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (count_en && tick && !expired) begin
      count <= count + 1'b1;
    end
  end

  assign expired = (count == LIMIT);

  if (CNT_W < 1 || LIMIT == '0) begin : g_bad_limit
    $error("apdu_idle_counter: bad width or limit");
  end

endmodule

// [hw/apdu_pkg.sv]
// constants and types shared by the auto power-down unit
package apdu_pkg;

  // inactivity counter
  localparam int         CNT_W      = 4;
  localparam logic [3:0] IDLE_LIMIT = 4'hf;

  // power mode registers
  localparam int         REG_W       = 8;
  localparam logic [7:0] PMR_A_RESET = 8'h00;
  localparam logic [7:0] PMR_C_RESET = 8'h00;
  localparam logic [7:0] PMR_A_MASK  = 8'h38;
  localparam logic [7:0] PMR_C_MASK  = 8'h7d;

  // power_mode_reg_a fields
  localparam int PMR_A_FAST_OFF    = 3;
  localparam int PMR_A_CLK_ARRAY   = 4;
  localparam int PMR_A_CLK_MCELL   = 5;

  // power_mode_reg_c blocking fields
  localparam int PMR_C_ADDR_LOW    = 0;
  localparam int PMR_C_CNTL0       = 2;
  localparam int PMR_C_CNTL1       = 3;
  localparam int PMR_C_CNTL2       = 4;
  localparam int PMR_C_STROBE      = 5;
  localparam int PMR_C_WRH         = 6;

  // bus widths
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 16;
  localparam int ADDR_LOW = 8;
  localparam int CNTL_W   = 3;
  localparam int MSEL_W   = 4;

  typedef enum logic {
    APDU_RUN,
    APDU_POWERDOWN
  } apdu_mode_type;

endpackage

// [hw/apdu_sync.sv]
// two flip-flop synchroniser bank for pins entering the core clock domain
`timescale 1ns/1ps
module apdu_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,  // core clock
  input  wire logic         rst,       // async reset, active high
  input  wire logic [W-1:0] async_in,  // pin levels
  output logic      [W-1:0] sync_out   // synchronised levels
);

  logic [W-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          stage1[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

  if (W < 1) begin : g_bad_width
    $error("apdu_sync: width must be at least 1");
  end

endmodule

// [hw/apdu_top.sv]
// auto power-down unit: strobe watch, power-down mode, signal blocking
//
// What this block does
// - When enabled, a four bit counter starts counting logic clock periods once strobe activity stops.
// - After fifteen idle logic clock periods the power-down flag rises and power-down mode begins.
// - Enabling the unit enables power-down mode with no further enable.
// - Strobe pulsing during power-down returns the device to normal operation at once.
// - A low chip select or a high reset wake input also returns the device to normal operation.
// - In power-down the address and data bus is frozen away from memories and logic arrays, and memories are deselected.
// - Blocking the logic clock from the logic arrays never stops it reaching the counter.
// - In power-down general and logic outputs hold, address outputs are undefined, data and peripheral ports float.
// - Power-down leaves logic array clocks running and floats the ports; only the fast-mode bit sets array fast mode.
// - A high chip select disables flash, SRAM and the register window without blocking anything else.
// - Each blocking bit set by software stops its signal at one destination only: the array inputs, the array clock or the macrocell clock.
// - The fast-mode bit resets to fast mode on, and setting it turns fast mode off.
// - The counter runs only when enabled and the strobe sits still at the selected polarity.
// - Fast mode off is bit 3 of the first power mode register, 1 off and 0 on.
// - Bits 4 and 5 of the first power mode register cut the logic clock from the array and macrocells.
`timescale 1ns/1ps
module apdu_top #(
  parameter int ADDR_W   = apdu_pkg::ADDR_W,
  parameter int DATA_W   = apdu_pkg::DATA_W,
  parameter int ADDR_LOW = apdu_pkg::ADDR_LOW,
  parameter int CNTL_W   = apdu_pkg::CNTL_W,
  parameter int MSEL_W   = apdu_pkg::MSEL_W
) (
  input  wire logic                     core_clk,         // core clock, 125 MHz
  input  wire logic                     rst,              // async reset, active high
  // pins from the microcontroller side
  input  wire logic                     strobe_pin,       // address strobe pin
  input  wire logic                     logic_clock_pin,  // logic clock pin
  input  wire logic                     chip_select_pin,  // chip select pin, low selects
  input  wire logic                     reset_wake_pin,   // reset input, high wakes
  input  wire logic [ADDR_W-1:0]        mcu_addr_pin,     // address bus pins
  input  wire logic [DATA_W-1:0]        mcu_data_pin,     // data bus pins
  input  wire logic [CNTL_W-1:0]        mcu_cntl_pin,     // control strobe pins
  input  wire logic                     mcu_wrh_pin,      // high-byte write enable pin
  // configuration
  input  wire logic                     apd_enable,       // auto power-down unit enable
  input  wire logic                     strobe_polarity,  // idle strobe level to count on
  input  wire logic                     pmr_a_wr,         // write strobe, power_mode_reg_a
  input  wire logic                     pmr_c_wr,         // write strobe, power_mode_reg_c
  input  wire logic [apdu_pkg::REG_W-1:0] pmr_wdata,      // register write data
  output logic      [apdu_pkg::REG_W-1:0] power_mode_reg_a, // readback, first register
  output logic      [apdu_pkg::REG_W-1:0] power_mode_reg_c, // readback, third register
  // requests from decode logic and port logic
  input  wire logic [MSEL_W-1:0]        mem_sel_req,      // flash pri, flash sec, sram, io win
  input  wire logic                     data_port_req,    // data port wants to drive
  input  wire logic                     periph_req,       // peripheral port wants to drive
  // status
  output logic                          powerdown_flag,   // power-down mode active
  output logic      [apdu_pkg::CNT_W-1:0] idle_count,     // inactivity count
  // to memories
  output logic      [ADDR_W-1:0]        mem_addr,         // address seen by memories
  output logic      [DATA_W-1:0]        mem_data,         // data seen by memories
  output logic      [MSEL_W-1:0]        mem_select,       // memory and window selects
  // to logic arrays
  output logic      [ADDR_W-1:0]        la_addr,          // address seen by logic arrays
  output logic      [DATA_W-1:0]        la_data,          // data seen by logic arrays
  output logic      [CNTL_W-1:0]        la_cntl,          // control seen by logic arrays
  output logic                          la_strobe,        // strobe seen by logic arrays
  output logic                          la_wrh,           // high-byte write seen by arrays
  output logic                          la_clock,         // logic clock to array
  output logic                          mcell_clock,      // logic clock to macrocells
  output logic                          la_fast_mode,     // logic arrays in fast mode
  // port drivers
  output logic                          data_port_oe_n,   // data port enable, low drives
  output logic                          periph_oe_n,      // peripheral port enable, low drives
  output logic                          addr_out_valid    // latched address outputs defined
);

  localparam int PIN_W = 4 + ADDR_W + DATA_W + CNTL_W + 1;

  // ---------------------------------------------------------------- pin sync
  logic [PIN_W-1:0]  pins_sync;
  logic              strobe_s;
  logic              lclk_s;
  logic              csel_n_s;
  logic              wake_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic [CNTL_W-1:0] cntl_s;
  logic              wrh_s;

  apdu_sync #(
    .W (PIN_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({strobe_pin, logic_clock_pin, chip_select_pin, reset_wake_pin,
                mcu_addr_pin, mcu_data_pin, mcu_cntl_pin, mcu_wrh_pin}),
    .sync_out (pins_sync)
  );

  assign {strobe_s, lclk_s, csel_n_s, wake_s, addr_s, data_s, cntl_s, wrh_s} = pins_sync;

  // ---------------------------------------------------------------- edge detect
  logic strobe_prev;
  logic lclk_prev;
  logic strobe_edge;
  logic lclk_tick;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strobe_prev <= 1'b0;
      lclk_prev   <= 1'b0;
    end else begin
      strobe_prev <= strobe_s;
      lclk_prev   <= lclk_s;
    end
  end

  // the logic clock is sampled, so it must run well below half of core_clk
  assign strobe_edge = strobe_s ^ strobe_prev;
  assign lclk_tick   = lclk_s & ~lclk_prev;

  // ---------------------------------------------------------------- power mode registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power_mode_reg_a <= apdu_pkg::PMR_A_RESET;
    end else if (pmr_a_wr) begin
      power_mode_reg_a <= pmr_wdata & apdu_pkg::PMR_A_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      power_mode_reg_c <= apdu_pkg::PMR_C_RESET;
    end else if (pmr_c_wr) begin
      power_mode_reg_c <= pmr_wdata & apdu_pkg::PMR_C_MASK;
    end
  end

  // ---------------------------------------------------------------- inactivity counter
  logic strobe_idle_level;
  logic wake;
  logic expired;

  assign strobe_idle_level = (strobe_s == strobe_polarity);
  // any wake source restarts the idle period from zero
  assign wake = strobe_edge | ~csel_n_s | wake_s | ~apd_enable;

  apdu_idle_counter #(
    .CNT_W (apdu_pkg::CNT_W),
    .LIMIT (apdu_pkg::IDLE_LIMIT)
  ) u_idle (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (wake),
    .count_en (apd_enable & strobe_idle_level),
    .tick     (lclk_tick),
    .count    (idle_count),
    .expired  (expired)
  );

  // ---------------------------------------------------------------- mode machine
  apdu_pkg::apdu_mode_type mode;
  apdu_pkg::apdu_mode_type next_mode;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      apdu_pkg::APDU_RUN: begin
        // power-down mode follows the unit enable, no separate switch
        if (!wake && expired) begin
          next_mode = apdu_pkg::APDU_POWERDOWN;
        end
      end
      apdu_pkg::APDU_POWERDOWN: begin
        if (wake) begin
          next_mode = apdu_pkg::APDU_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode <= apdu_pkg::APDU_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      powerdown_flag <= 1'b0;
    end else begin
      powerdown_flag <= (next_mode == apdu_pkg::APDU_POWERDOWN);
    end
  end

  logic pd_next;
  assign pd_next = (next_mode == apdu_pkg::APDU_POWERDOWN);

  // ---------------------------------------------------------------- memory side
  // frozen rather than zeroed, so no edge reaches the memories while asleep
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_addr <= '0;
      mem_data <= '0;
    end else if (!pd_next) begin
      mem_addr <= addr_s;
      mem_data <= data_s;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_select <= '0;
    end else begin
      mem_select <= (pd_next || csel_n_s) ? '0 : mem_sel_req;
    end
  end

  // ---------------------------------------------------------------- logic array side
  logic pass_addr;
  logic pass_cntl0;
  logic pass_cntl1;
  logic pass_cntl2;
  logic pass_strobe;
  logic pass_wrh;

  // chip select is deliberately absent here: it gates memories only
  assign pass_addr   = !pd_next && !power_mode_reg_c[apdu_pkg::PMR_C_ADDR_LOW];
  assign pass_cntl0  = !power_mode_reg_c[apdu_pkg::PMR_C_CNTL0];
  assign pass_cntl1  = !power_mode_reg_c[apdu_pkg::PMR_C_CNTL1];
  assign pass_cntl2  = !power_mode_reg_c[apdu_pkg::PMR_C_CNTL2];
  assign pass_strobe = !power_mode_reg_c[apdu_pkg::PMR_C_STROBE];
  assign pass_wrh    = !power_mode_reg_c[apdu_pkg::PMR_C_WRH];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      la_addr <= '0;
    end else begin
      if (!pd_next) begin
        la_addr[ADDR_W-1:ADDR_LOW] <= addr_s[ADDR_W-1:ADDR_LOW];
      end
      if (pass_addr) begin
        la_addr[ADDR_LOW-1:0] <= addr_s[ADDR_LOW-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      la_data <= '0;
    end else if (!pd_next) begin
      la_data <= data_s;
    end
  end

  // control lines are not bus signals, so power-down leaves them alone
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      la_cntl   <= '0;
      la_strobe <= 1'b0;
      la_wrh    <= 1'b0;
    end else begin
      if (pass_cntl0) la_cntl[0] <= cntl_s[0];
      if (pass_cntl1) la_cntl[1] <= cntl_s[1];
      if (pass_cntl2) la_cntl[2] <= cntl_s[2];
      if (pass_strobe) la_strobe <= strobe_s;
      if (pass_wrh) la_wrh <= wrh_s;
    end
  end

  // counter clock path above never looks at these blocking bits
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      la_clock    <= 1'b0;
      mcell_clock <= 1'b0;
    end else begin
      la_clock    <= lclk_s & ~power_mode_reg_a[apdu_pkg::PMR_A_CLK_ARRAY];
      mcell_clock <= lclk_s & ~power_mode_reg_a[apdu_pkg::PMR_A_CLK_MCELL];
    end
  end

  // fast mode depends on the register only, never on power-down
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      la_fast_mode <= 1'b1;
    end else begin
      la_fast_mode <= ~power_mode_reg_a[apdu_pkg::PMR_A_FAST_OFF];
    end
  end

  // ---------------------------------------------------------------- port drivers
  // general and logic outputs are not touched here, so they keep their levels
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      data_port_oe_n <= 1'b1;
      periph_oe_n    <= 1'b1;
      addr_out_valid <= 1'b0;
    end else begin
      data_port_oe_n <= pd_next | ~data_port_req;
      periph_oe_n    <= pd_next | ~periph_req;
      addr_out_valid <= ~pd_next;
    end
  end

  // control blocking is wired bit by bit, so only three control lines are served
  if (CNTL_W != 3 || MSEL_W < 1 || ADDR_LOW < 1 || ADDR_LOW >= ADDR_W || DATA_W < 1)
  begin : g_bad_width
    $error("apdu_top: unsupported bus widths");
  end

endmodule

// [tb/apdu_mcu_model.sv]
// behavioural microcontroller side: strobe, logic clock and a noisy bus
`timescale 1ns/1ps
module apdu_mcu_model (
  input  wire logic        core_clk,        // core clock
  input  wire logic        run_lclk,        // let the logic clock run
  input  wire logic        pulse_go,        // pulse the strobe
  input  wire logic        idle_lvl,        // strobe level while idle
  output logic             strobe_pin,      // address strobe
  output logic             logic_clock_pin, // logic clock
  output logic      [15:0] mcu_addr_pin,    // address bus
  output logic      [15:0] mcu_data_pin     // data bus
);
  logic [2:0] ph = 3'h0;
  initial begin
    strobe_pin = 1'b0;
    logic_clock_pin = 1'b0;
    mcu_addr_pin = 16'h1234;
    mcu_data_pin = 16'hedcb;
  end
  // bus keeps moving while the mcu sleeps, like other bus users would
  // rising-edge updates, so the bench's falling-edge controls never race this model
  // strobe pulses every cycle, so no logic clock tick falls between two strobe edges
  always @(posedge core_clk) begin
    ph <= ph + 3'h1;
    mcu_addr_pin <= mcu_addr_pin + 16'h0101;
    mcu_data_pin <= ~mcu_data_pin;
    logic_clock_pin <= run_lclk & ph[2];
    if (!pulse_go) begin
      strobe_pin <= idle_lvl;
    end else begin
      strobe_pin <= ~strobe_pin;
    end
  end
endmodule

// [tb/apdu_properties.sv]
// checker for the auto power-down unit, bound to its top module
`timescale 1ns/1ps
module apdu_checker (
  input wire logic        core_clk,         // core clock
  input wire logic        rst,              // async reset
  input wire logic        strobe_pin,       // strobe pin
  input wire logic        chip_select_pin,  // chip select pin
  input wire logic        pmr_a_wr,         // write strobe, first register
  input wire logic [7:0]  pmr_wdata,        // write data
  input wire logic [7:0]  power_mode_reg_a, // first register
  input wire logic        powerdown_flag,   // power-down flag
  input wire logic [3:0]  idle_count,       // inactivity count
  input wire logic [15:0] mem_addr,         // memory address
  input wire logic [3:0]  mem_select,       // memory selects
  input wire logic        la_clock,         // array clock
  input wire logic        mcell_clock,      // macrocell clock
  input wire logic        la_fast_mode,     // fast mode
  input wire logic        data_port_oe_n,   // data port enable
  input wire logic        periph_oe_n,      // peripheral enable
  input wire logic        addr_out_valid    // address outputs defined
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  pd_entry_a: assert property (
    $rose(powerdown_flag) |-> $past(idle_count) == 4'hf) else $error("flag rose early");
  count_step_a: assert property (
    idle_count != $past(idle_count) |->
      idle_count == 4'h0 || idle_count == $past(idle_count) + 4'h1)
    else $error("count jumped");
  pd_block_a: assert property (
    powerdown_flag && $past(powerdown_flag) |-> mem_select == 4'h0 && $stable(mem_addr))
    else $error("bus reached memories in power-down");
  pd_ports_a: assert property (
    powerdown_flag && $past(powerdown_flag) |->
      data_port_oe_n && periph_oe_n && !addr_out_valid) else $error("ports active");
  fast_mode_a: assert property (
    la_fast_mode == !$past(power_mode_reg_a[3])) else $error("fast mode wrong");
  reg_a_mask_a: assert property (
    pmr_a_wr |=> power_mode_reg_a == ($past(pmr_wdata) & 8'h38)) else $error("reg a wrong");
  clk_block_a: assert property (
    (!$past(power_mode_reg_a[4]) || !la_clock) && (!$past(power_mode_reg_a[5]) || !mcell_clock))
    else $error("blocked clock passed");
  cs_off_a: assert property (
    chip_select_pin [*4] |=> mem_select == 4'h0) else $error("select while deselected");
  wake_strobe_a: assert property (
    powerdown_flag && $changed(strobe_pin) |-> ##[1:5] !powerdown_flag)
    else $error("no wake on strobe");
  wake_cs_a: assert property (
    powerdown_flag && !chip_select_pin |-> ##[1:5] !powerdown_flag)
    else $error("no wake on select");
  cover property ($rose(powerdown_flag));
  cover property ($fell(powerdown_flag));
  cover property (power_mode_reg_a[4] && powerdown_flag);
endmodule
bind apdu_top apdu_checker u_apdu_checker (.core_clk, .rst, .strobe_pin, .chip_select_pin,
  .pmr_a_wr, .pmr_wdata, .power_mode_reg_a, .powerdown_flag, .idle_count, .mem_addr,
  .mem_select, .la_clock, .mcell_clock, .la_fast_mode, .data_port_oe_n, .periph_oe_n,
  .addr_out_valid);

// [tb/testbench.sv]
// self-checking bench for the auto power-down unit
`timescale 1ns/1ps
module testbench;
  logic        core_clk = 1'b0, rst = 1'b1, cs = 1'b1, wake = 1'b0, en = 1'b0;
  logic        pol = 1'b1, lvl = 1'b1, awr = 1'b0, cwr = 1'b0, run = 1'b0, go = 1'b1;
  logic        wrh = 1'b0, strobe, lclk, flag, la_strobe, la_wrh, la_clock, mcell_clock;
  logic        fast, doe_n, poe_n, aov;
  logic        dreq = 1'b1, preq = 1'b1;
  logic [2:0]  cntl = 3'h0, la_cntl;
  logic [7:0]  wd = 8'h00, rega, regc;
  logic [3:0]  msel_req = 4'hf, msel, idle_count;
  logic [15:0] a_pin, d_pin, mem_addr, mem_data, la_addr, la_data;
  int          n_errors = 0, num_checks = 0, cyc = 0;
  apdu_top u_apdu_top (.core_clk(core_clk), .rst(rst), .strobe_pin(strobe),
    .logic_clock_pin(lclk), .chip_select_pin(cs), .reset_wake_pin(wake),
    .mcu_addr_pin(a_pin), .mcu_data_pin(d_pin), .mcu_cntl_pin(cntl), .mcu_wrh_pin(wrh),
    .apd_enable(en), .strobe_polarity(pol), .pmr_a_wr(awr), .pmr_c_wr(cwr),
    .pmr_wdata(wd), .power_mode_reg_a(rega), .power_mode_reg_c(regc),
    .mem_sel_req(msel_req), .data_port_req(dreq), .periph_req(preq),
    .powerdown_flag(flag), .idle_count(idle_count), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_select(msel), .la_addr(la_addr), .la_data(la_data),
    .la_cntl(la_cntl), .la_strobe(la_strobe), .la_wrh(la_wrh), .la_clock(la_clock),
    .mcell_clock(mcell_clock), .la_fast_mode(fast), .data_port_oe_n(doe_n),
    .periph_oe_n(poe_n), .addr_out_valid(aov));
  apdu_mcu_model u_apdu_mcu_model (.core_clk(core_clk), .run_lclk(run), .pulse_go(go),
    .idle_lvl(lvl), .strobe_pin(strobe), .logic_clock_pin(lclk), .mcu_addr_pin(a_pin),
    .mcu_data_pin(d_pin));
  always #4 core_clk = ~core_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // a hang counts as a mismatch and still ends in the report
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic wait_flag(input logic want, input int lim);
    int i;
    i = 0;
    while (flag !== want && i < lim) begin
      @(negedge core_clk);
      i++;
    end
    chk({15'h0, flag}, {15'h0, want});
  endtask
  task automatic wrreg(input logic sel_c, input logic [7:0] d);
    awr = !sel_c;
    cwr = sel_c;
    wd = d;
    @(negedge core_clk);
    awr = 1'b0;
    cwr = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic go_pd();
    lvl = pol;
    go = 1'b0;
    wait_flag(1'b1, 400);
    chk({12'h0, idle_count}, 16'h000f);
  endtask
  // reset values are looked at while reset is still applied
  task automatic t_reset();
    chk({rega, regc}, 16'h0000);
    chk({13'h0, fast, doe_n, poe_n}, 16'h0007);
  endtask
  task automatic t_regs();
    logic       seen;
    logic       ls;
    logic       lw;
    logic [7:0] lo;
    logic [7:0] hi;
    chk({14'h0, doe_n, poe_n}, 16'h0000);
    dreq = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({14'h0, doe_n, poe_n}, 16'h0002);
    dreq = 1'b1;
    preq = 1'b0;
    repeat (2) @(negedge core_clk);
    chk({14'h0, doe_n, poe_n}, 16'h0001);
    preq = 1'b1;
    run = 1'b1;
    en = 1'b1;
    seen = 1'b0;
    repeat (24) begin
      @(negedge core_clk);
      seen = seen | (la_clock & mcell_clock);
    end
    chk({15'h0, seen}, 16'h0001);
    wrreg(1'b0, 8'hff);
    chk({8'h0, rega}, 16'h0038);
    chk({15'h0, fast}, 16'h0000);
    seen = 1'b0;
    repeat (24) begin
      @(negedge core_clk);
      seen = seen | la_clock | mcell_clock;
    end
    chk({15'h0, seen}, 16'h0000);
    wrreg(1'b1, 8'hff);
    chk({8'h0, regc}, 16'h007d);
    ls = la_strobe;
    lw = la_wrh;
    lo = la_addr[7:0];
    hi = la_addr[15:8];
    wrh = 1'b1;
    repeat (20) @(negedge core_clk);
    chk({15'h0, la_strobe}, {15'h0, ls});
    chk({15'h0, la_wrh}, {15'h0, lw});
    chk({8'h0, la_addr[7:0]}, {8'h0, lo});
    chk({15'h0, la_addr[15:8] != hi}, 16'h0001);
    wrreg(1'b1, 8'h00);
    chk({15'h0, la_wrh}, 16'h0001);
    wrh = 1'b0;
    wrreg(1'b0, 8'h30);
  endtask
  // clocks to the arrays stay blocked here, the counter must still run
  task automatic t_pd(input logic p);
    logic [15:0] a;
    logic [15:0] md;
    logic [15:0] la;
    logic [15:0] ld;
    pol = p;
    go_pd();
    repeat (2) @(negedge core_clk);
    chk({12'h0, msel}, 16'h0000);
    chk({13'h0, doe_n, poe_n, aov}, 16'h0006);
    chk({15'h0, fast}, 16'h0001);
    a = mem_addr;
    md = mem_data;
    la = la_addr;
    ld = la_data;
    // odd count, the data pins invert every cycle
    repeat (5) @(negedge core_clk);
    chk(mem_addr, a);
    chk(mem_data, md);
    chk(la_addr, la);
    chk(la_data, ld);
    cntl = 3'h5;
    repeat (5) @(negedge core_clk);
    chk({13'h0, la_cntl}, 16'h0005);
    cntl = 3'h0;
    go = 1'b1;
    wait_flag(1'b0, 10);
    repeat (3) @(negedge core_clk);
    chk({12'h0, idle_count}, 16'h0000);
    chk({15'h0, mem_addr != a}, 16'h0001);
  endtask
  task automatic t_wake_cs();
    go_pd();
    cs = 1'b0;
    wait_flag(1'b0, 8);
    repeat (4) @(negedge core_clk);
    chk({12'h0, msel}, 16'h000f);
    cs = 1'b1;
    repeat (5) @(negedge core_clk);
    chk({12'h0, msel}, 16'h0000);
    go = 1'b1;
    repeat (8) @(negedge core_clk);
  endtask
  task automatic t_wake_rst();
    go_pd();
    wake = 1'b1;
    wait_flag(1'b0, 8);
    wake = 1'b0;
    go = 1'b1;
    repeat (8) @(negedge core_clk);
  endtask
  task automatic t_no_count();
    lvl = ~pol;
    go = 1'b0;
    repeat (200) @(negedge core_clk);
    chk({11'h0, flag, idle_count}, 16'h0000);
    lvl = pol;
    en = 1'b0;
    repeat (200) @(negedge core_clk);
    chk({11'h0, flag, idle_count}, 16'h0000);
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    t_reset();
    rst = 1'b0;
    @(negedge core_clk);
    t_regs();
    t_pd(1'b1);
    t_pd(1'b0);
    t_wake_cs();
    t_wake_rst();
    t_no_count();
    wrap_up();
  end
endmodule
